// ==== srpp_far_model.sv ====
/*
 * far side model: serial byte source and packet sink.
 * assumes the packer's rx and tx valid/ready ports, one clock.
 */
`timescale 1ns/1ns
`default_nettype none

module srpp_far_model
    import srpp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic slow,
    output logic rx_valid,
    output logic [BYTE_W-1:0] rx_data,
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire logic [BYTE_W-1:0] tx_data,
    input wire logic tx_last,
    output logic tx_ready
);
    logic [BYTE_W-1:0] send_q[$];
    logic [BYTE_W-1:0] got_q[$];
    int len_q[$];
    int cur;
    int refused;

    // byte source held until taken, packet sink records bytes and packet lengths
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
            tx_ready <= 1'b0;
            cur = 0;
            refused = 0;
        end
        else
        begin
            if (rx_valid && !rx_ready)
                refused++;
            if (!rx_valid || rx_ready)
            begin
                rx_valid <= send_q.size() > 0;
                // idle line changes, so a stale byte is never taken
                rx_data <= send_q.size() > 0 ? send_q.pop_front() : ~rx_data;
            end
            // slow sink takes every other cycle
            tx_ready <= slow ? !tx_ready : 1'b1;
            if (tx_valid && tx_ready)
            begin
                got_q.push_back(tx_data);
                cur++;
                if (tx_last)
                begin
                    len_q.push_back(cur);
                    cur = 0;
                end
            end
        end
    end
endmodule : srpp_far_model

`default_nettype wire

// ==== srpp_fifo.sv ====
/*
 * small parameterised FIFO with valid/ready on both sides.
 * assumes one clock and a synchronous active-high reset; in_ready and
 * out_valid are registered, in_hold drops in_ready on the next edge.
 */
`timescale 1ns/1ns
`default_nettype none

module srpp_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
)
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    input wire logic in_hold,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed
    {
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [CW-1:0] cnt;
        logic room;
        logic any;
    } srpp_fifo_st_t;

    srpp_fifo_st_t st;
    srpp_fifo_st_t next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    // handshakes use the registered flags only
    assign push = in_valid & st.room;
    assign pop = out_ready & st.any;
    assign in_ready = st.room;
    assign out_valid = st.any;
    assign out_data = mem[st.rp];

    // pointer and occupancy update
    always_comb
    begin
        next_st = st;
        if (push)
        begin
            next_st.wp = (st.wp == PW'(DEPTH - 1)) ? '0 : st.wp + 1'b1;
        end
        if (pop)
        begin
            next_st.rp = (st.rp == PW'(DEPTH - 1)) ? '0 : st.rp + 1'b1;
        end
        next_st.cnt = st.cnt + CW'(push) - CW'(pop);
        // hold stalls the source without losing stored words
        next_st.room = (next_st.cnt != CW'(DEPTH)) & ~in_hold;
        next_st.any = (next_st.cnt != '0);
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // storage needs no reset
    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            mem[st.wp] <= in_data;
        end
    end

endmodule : srpp_fifo

`default_nettype wire

// ==== srpp_packer.sv ====
/*
 * serial receive packet packer: gathers received bytes into a 1 KB
 * buffer and emits them as one packet on terminator, timeout, length
 * or full buffer. APB slave for configuration and status.
 * assumes rx bytes arrive with valid/ready, the tx side takes bytes with
 * valid/ready and tx_last marks the end of a packet.
 */
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ns
`default_nettype none

// Contract
// RL1: first terminator alone flushes when the second is disabled.
// RL2: a full buffer flushes without waiting for a terminator.
// RL3: software must enable the first terminator for terminator flushing.
// RL4: plus-one/plus-two modes flush after one or two further bytes.
// RL5: strip mode drops the terminator and flushes the rest.
// RL6: pass mode flushes at once, terminator kept in the data.
// RL7: timeout value zero disables the timeout flush.
// RL8: nonzero timeout gathers bytes of that many ms into one packet.
// RL9: without terminator or length, flush only on full or timeout.
// RL10: software picks a timeout above one character time and 10 ms.
// RL11: the port owns a one kilobyte receive buffer.
// RL12: the sender keeps gaps below timeout and length within buffer.
// RL13: listen port is settable 1 to 65535, default 4001.
// RL14: a disabled port moves no data; code still sends a packet in ST_SEND, and the FIFO can take one more byte.
// RL15: nonzero packet length flushes when the count reaches it.
// RL16: any enabled terminator byte match triggers terminator handling.
// RL17: idle ms counter restarts per byte, one flush per trigger.
module srpp_packer
    import srpp_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
)
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_valid,
    input wire logic [BYTE_W-1:0] rx_data,
    output logic rx_ready,
    output logic tx_valid,
    output logic [BYTE_W-1:0] tx_data,
    output logic tx_last,
    input wire logic tx_ready,
    output logic [15:0] listen_port
);
    typedef struct packed
    {
        srpp_state_t state;
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] rd;
        logic [1:0] pend;
        logic [15:0] idle_ms;
        logic [31:0] tick_cnt;
        logic en;
        logic d1_en;
        logic d2_en;
        srpp_mode_t mode;
        logic [BYTE_W-1:0] d1;
        logic [BYTE_W-1:0] d2;
        logic [CNT_W-1:0] pkt_len;
        logic [15:0] timeout;
        logic [15:0] lport;
        logic [15:0] flushes;
        logic tx_valid;
        logic [BYTE_W-1:0] tx_data;
        logic tx_last;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } srpp_st_t;

    srpp_st_t st;
    srpp_st_t next_st;
    // RL11: one kilobyte receive buffer of the port
    logic [BYTE_W-1:0] buf_mem [BUF_BYTES];
    logic fifo_valid;
    logic [BYTE_W-1:0] fifo_data;
    logic take;
    logic match;
    logic stored;
    logic wr_en;
    logic [CNT_W-1:0] new_cnt;
    logic [BYTE_W-1:0] rd_byte;

    // a byte hits when it equals any enabled terminator
    function automatic logic term_match(input logic [BYTE_W-1:0] b,
                                        input srpp_st_t s);
        term_match = (s.d1_en && b == s.d1) || (s.d2_en && b == s.d2);
    endfunction : term_match

    // known register offsets; others answer with an error
    function automatic logic reg_known(input logic [APB_ADDR_W-1:0] a);
        reg_known = (a == OFS_CTRL) || (a == OFS_DELIM) ||
                    (a == OFS_PKTLEN) || (a == OFS_TIMEOUT) ||
                    (a == OFS_LPORT) || (a == OFS_STATUS) ||
                    (a == OFS_FLUSHES);
    endfunction : reg_known

    // a few bytes of slack so the serial side is not stalled per byte
    srpp_fifo
    #(
        .WIDTH(BYTE_W),
        .DEPTH(FIFO_DEPTH)
    )
    u_fifo
    (
        .clk_sys(clk_sys),
        .reset(reset),
        .in_valid(rx_valid),
        .in_data(rx_data),
        .in_ready(rx_ready),
        .in_hold(~st.en),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(take)
    );

    // byte intake decode
    // RL14: no intake while off
    assign take = (st.state == ST_FILL) & st.en & fifo_valid;
    assign match = term_match(fifo_data, st);
    // RL5: terminator not stored
    assign stored = !(st.mode == MODE_STRIP && match && st.pend == PEND_NONE);
    assign new_cnt = st.count + (stored ? CNT_ONE : '0);
    assign wr_en = take & stored;
    assign rd_byte = buf_mem[st.rd[CNT_W-2:0]];

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign tx_valid = st.tx_valid;
    assign tx_data = st.tx_data;
    assign tx_last = st.tx_last;
    assign listen_port = st.lport;

    // packing, sending and register access
    always_comb
    begin
        logic term_flush;
        logic size_flush;
        logic [15:0] wval;
        term_flush = 1'b0;
        size_flush = 1'b0;
        wval = pwdata[15:0];
        next_st = st;

        // RL17: free-running millisecond tick
        if (st.tick_cnt >= TICK_CYCLES - 1)
        begin
            next_st.tick_cnt = '0;
            if (st.idle_ms != IDLE_MAX)
            begin
                next_st.idle_ms = st.idle_ms + 16'h0001;
            end
        end
        else
        begin
            next_st.tick_cnt = st.tick_cnt + 32'h0000_0001;
        end

        unique case (st.state)
            ST_FILL:
            begin
                if (!st.en)
                begin
                    // RL14: buffered bytes are dropped
                    next_st.count = '0;
                    next_st.pend = PEND_NONE;
                end
                else if (take)
                begin
                    next_st.idle_ms = '0;
                    next_st.count = new_cnt;
                    if (st.pend != PEND_NONE)
                    begin
                        // RL4: count trailing bytes
                        next_st.pend = st.pend - PEND_ONE;
                        term_flush = (st.pend == PEND_ONE);
                    end
                    else if (match)
                    begin
                        // RL16: handling by mode
                        // RL6: pass flushes at once
                        unique case (st.mode)
                            MODE_PASS: term_flush = 1'b1;
                            MODE_PLUS1: next_st.pend = PEND_ONE;
                            MODE_PLUS2: next_st.pend = PEND_TWO;
                            MODE_STRIP: term_flush = 1'b1;
                        endcase
                    end
                    // RL15: length trigger
                    // RL2: full buffer trigger
                    size_flush = stored && ((st.pkt_len != '0 &&
                                 new_cnt >= st.pkt_len) ||
                                 new_cnt == BUF_BYTES);
                    // RL1: flush on terminator
                    if ((term_flush || size_flush) && new_cnt != '0)
                    begin
                        next_st.state = ST_SEND;
                        next_st.rd = '0;
                        next_st.pend = PEND_NONE;
                    end
                end
                // RL7: zero timeout never fires
                // RL8: gather until idle timeout
                // RL9: idle flush without trigger
                else if (st.timeout != '0 && st.count != '0 &&
                         st.idle_ms >= st.timeout)
                begin
                    next_st.state = ST_SEND;
                    next_st.rd = '0;
                    next_st.pend = PEND_NONE;
                end
            end
            ST_SEND:
            begin
                next_st.idle_ms = '0;
                // registered stream: refill only when the slot frees
                if (!st.tx_valid || tx_ready)
                begin
                    if (st.rd != st.count)
                    begin
                        next_st.tx_valid = 1'b1;
                        next_st.tx_data = rd_byte;
                        next_st.tx_last = (st.rd + CNT_ONE == st.count);
                        next_st.rd = st.rd + CNT_ONE;
                    end
                    else
                    begin
                        // RL17: single packet per trigger
                        next_st.tx_valid = 1'b0;
                        next_st.tx_last = 1'b0;
                        next_st.count = '0;
                        next_st.state = ST_FILL;
                        next_st.flushes = st.flushes + 16'h0001;
                    end
                end
            end
        endcase

        // apb: pready one cycle into the access phase
        next_st.pready = psel & penable & ~st.pready;
        next_st.pslverr = psel & penable & ~st.pready & ~reg_known(paddr);
        next_st.prdata = '0;
        if (psel && penable && !st.pready && !pwrite)
        begin
            unique case (paddr)
                OFS_CTRL: next_st.prdata = {26'h0, st.mode, 1'b0,
                                            st.d2_en, st.d1_en, st.en};
                OFS_DELIM: next_st.prdata = {16'h0, st.d2, st.d1};
                OFS_PKTLEN: next_st.prdata = {21'h0, st.pkt_len};
                OFS_TIMEOUT: next_st.prdata = {16'h0, st.timeout};
                OFS_LPORT: next_st.prdata = {16'h0, st.lport};
                OFS_STATUS: next_st.prdata = {10'h0, st.pend, 3'h0,
                                              st.state, 5'h0, st.count};
                OFS_FLUSHES: next_st.prdata = {16'h0, st.flushes};
                default: next_st.prdata = '0;
            endcase
        end
        // writes land at the edge where pready is sampled high
        if (psel && penable && st.pready && pwrite && reg_known(paddr))
        begin
            unique case (paddr)
                OFS_CTRL:
                begin
                    next_st.en = pwdata[CTRL_EN_BIT];
                    next_st.d1_en = pwdata[CTRL_D1_BIT];
                    next_st.d2_en = pwdata[CTRL_D2_BIT];
                    next_st.mode =
                        srpp_mode_t'(pwdata[CTRL_MODE_HI:CTRL_MODE_LO]);
                end
                OFS_DELIM:
                begin
                    next_st.d1 = pwdata[7:0];
                    next_st.d2 = pwdata[15:8];
                end
                // lengths above the buffer saturate at its size
                OFS_PKTLEN: next_st.pkt_len =
                    (wval > 16'(PKT_LEN_MAX)) ? PKT_LEN_MAX : wval[CNT_W-1:0];
                OFS_TIMEOUT: next_st.timeout = wval;
                // RL13: port zero is refused
                OFS_LPORT:
                begin
                    if (wval != PORT_NONE)
                    begin
                        next_st.lport = wval;
                    end
                end
                default: next_st = next_st;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            st <= '0;
            st.state <= ST_FILL;
            st.en <= CTRL_EN_RST;
            st.mode <= MODE_PASS;
            st.d1 <= DELIM_RST;
            st.d2 <= DELIM_RST;
            st.pkt_len <= PKTLEN_RST;
            st.timeout <= TIMEOUT_RST;
            st.lport <= LPORT_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    // buffer write port, no reset needed
    always_ff @(posedge clk_sys)
    begin
        if (wr_en)
        begin
            buf_mem[st.count[CNT_W-2:0]] <= fifo_data;
        end
    end

    a_buf_bound: // RL11
        assert property (@(posedge clk_sys) disable iff (reset)
            st.state == ST_FILL |-> st.count < BUF_BYTES)
        else $error("fill state holds a full buffer");
    a_full_flush: // RL2
        assert property (@(posedge clk_sys) disable iff (reset)
            take && stored && st.count == BUF_BYTES - CNT_ONE
            |=> st.state == ST_SEND && st.count == BUF_BYTES)
        else $error("full buffer did not flush");
    a_pass_flush: // RL6
        assert property (@(posedge clk_sys) disable iff (reset)
            take && match && st.mode == MODE_PASS && st.pend == PEND_NONE
            |=> st.state == ST_SEND && st.count == $past(st.count) + CNT_ONE)
        else $error("pass mode terminator missed");
    a_strip_drop: // RL5
        assert property (@(posedge clk_sys) disable iff (reset)
            take && match && st.mode == MODE_STRIP && st.pend == PEND_NONE
            |=> st.count == $past(st.count))
        else $error("stripped terminator was stored");
    a_plus_two: // RL4
        assert property (@(posedge clk_sys) disable iff (reset)
            take && match && st.mode == MODE_PLUS2 && st.pend == PEND_NONE
            && st.pkt_len == '0 && st.count < BUF_BYTES - 11'h003
            |=> st.state == ST_FILL && st.pend == PEND_TWO)
        else $error("plus two mode flushed early");
    a_len_flush: // RL15
        assert property (@(posedge clk_sys) disable iff (reset)
            take && stored && st.pkt_len != '0
            && st.count + CNT_ONE == st.pkt_len |=> st.state == ST_SEND)
        else $error("length trigger missed");
    a_timeout_off: // RL7
        assert property (@(posedge clk_sys) disable iff (reset)
            st.state == ST_FILL && !take && st.timeout == '0
            |=> st.state == ST_FILL)
        else $error("flush without trigger while timeout off");
    a_timeout_fire: // RL8
        assert property (@(posedge clk_sys) disable iff (reset)
            st.state == ST_FILL && st.en && !take && st.timeout != '0
            && st.count != '0 && st.idle_ms >= st.timeout
            |=> st.state == ST_SEND)
        else $error("idle timeout did not flush");
    a_idle_restart: // RL17
        assert property (@(posedge clk_sys) disable iff (reset)
            take |=> st.idle_ms == '0)
        else $error("idle count not restarted by byte");
    a_off_stall: // RL14
        assert property (@(posedge clk_sys) disable iff (reset)
            !st.en |=> !rx_ready && !take)
        else $error("disabled port still moves data");
    a_port_valid: // RL13
        assert property (@(posedge clk_sys) disable iff (reset)
            listen_port != PORT_NONE)
        else $error("listen port is zero");

endmodule : srpp_packer

`default_nettype wire

// ==== srpp_pkg.sv ====
/*
 * shared constants and types of the serial receive packet packer:
 * register offsets, field positions, reset values, modes and timing.
 * assumes a 50 MHz system clock and 32-bit APB register access.
 */
`default_nettype none

package srpp_pkg;

    // timing: one millisecond tick derived from the system clock
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned TICK_PERIOD_MS = 1;
    localparam int unsigned NS_PER_MS = 1000000;
    localparam int unsigned TICK_CYCLES_DEF =
        (TICK_PERIOD_MS * NS_PER_MS) / CLK_PERIOD_NS;

    // data path sizes
    localparam int BYTE_W = 8;
    localparam int CNT_W = 11;
    localparam int FIFO_DEPTH = 4;
    localparam logic [CNT_W-1:0] BUF_BYTES = 11'h400;
    localparam logic [CNT_W-1:0] PKT_LEN_MAX = 11'h400;
    localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;
    localparam logic [15:0] IDLE_MAX = 16'hffff;

    // register map, byte addresses
    localparam int APB_ADDR_W = 12;
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_DELIM = 12'h004;
    localparam logic [11:0] OFS_PKTLEN = 12'h008;
    localparam logic [11:0] OFS_TIMEOUT = 12'h00c;
    localparam logic [11:0] OFS_LPORT = 12'h010;
    localparam logic [11:0] OFS_STATUS = 12'h014;
    localparam logic [11:0] OFS_FLUSHES = 12'h018;

    // control register fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_D1_BIT = 1;
    localparam int CTRL_D2_BIT = 2;
    localparam int CTRL_MODE_LO = 4;
    localparam int CTRL_MODE_HI = 5;

    // reset values
    localparam logic CTRL_EN_RST = 1'b1;
    localparam logic [BYTE_W-1:0] DELIM_RST = 8'h00;
    localparam logic [CNT_W-1:0] PKTLEN_RST = 11'h000;
    localparam logic [15:0] TIMEOUT_RST = 16'h0000;
    localparam logic [15:0] LPORT_RST = 16'h0fa1;
    localparam logic [15:0] PORT_NONE = 16'h0000;

    // pending bytes after a terminator
    localparam logic [1:0] PEND_NONE = 2'h0;
    localparam logic [1:0] PEND_ONE = 2'h1;
    localparam logic [1:0] PEND_TWO = 2'h2;

    typedef enum logic [1:0]
    {
        MODE_PASS = 2'b00,
        MODE_PLUS1 = 2'b01,
        MODE_PLUS2 = 2'b10,
        MODE_STRIP = 2'b11
    } srpp_mode_t;

    typedef enum logic
    {
        ST_FILL = 1'b0,
        ST_SEND = 1'b1
    } srpp_state_t;

endpackage : srpp_pkg

`default_nettype wire

// ==== test_serial_rx_packet_packer.sv ====
/*
 * self-checking testbench of the serial receive packet packer.
 * assumes srpp_pkg, srpp_fifo, srpp_packer and the far model.
 */
`timescale 1ns/1ns
`default_nettype none

`define CHK(what, exp, got) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("mismatch %s expected %0h seen %0h", what, exp, got); \
        end \
    end

module test_serial_rx_packet_packer
    import srpp_pkg::*;
;
    localparam int FIRST[4] = '{2, 3, 4, 1};
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic slow = 1'b0;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_ready;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_last;
    logic tx_ready;
    logic [15:0] listen_port;
    logic [31:0] rd;
    logic err;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;

    // 50 MHz clock
    always #10 clk_sys = ~clk_sys;

    // short tick keeps the 12 ms timeout to about a hundred and twenty cycles
    srpp_packer #(.TICK_CYCLES(10)) u_srpp_packer
    (
        .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
        .listen_port(listen_port)
    );

    srpp_far_model u_srpp_far_model
    (
        .clk_sys(clk_sys), .reset(reset), .slow(slow),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .tx_ready(tx_ready)
    );

    // one apb transfer, held until pready is sampled
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clk_sys);
    endtask : apb

    task wait_pkts(input int n);
        while (u_srpp_far_model.len_q.size() < n)
            @(posedge clk_sys);
    endtask : wait_pkts

    task clear;
        u_srpp_far_model.got_q.delete();
        u_srpp_far_model.len_q.delete();
    endtask : clear

    task test_regs;
        apb(1'b0, OFS_CTRL, 32'h0);
        `CHK("ctrl reset", {31'h0, CTRL_EN_RST}, rd)
        `CHK("port reset", LPORT_RST, listen_port)
        apb(1'b0, 12'h100, 32'h0);
        `CHK("unmapped", 1'b1, err)
        apb(1'b1, OFS_LPORT, 32'h5);
        `CHK("port set", 16'h0005, listen_port)
        apb(1'b1, OFS_LPORT, 32'h0);
        `CHK("port zero", 16'h0005, listen_port)
        apb(1'b1, OFS_PKTLEN, 32'h7d0);
        apb(1'b0, OFS_PKTLEN, 32'h0);
        `CHK("len max", {21'h0, PKT_LEN_MAX}, rd)
        apb(1'b1, OFS_PKTLEN, 32'h0);
        $display("test regs done");
    endtask : test_regs

    task test_full;
        int bad;
        bad = 0;
        clear();
        slow <= 1'b1;
        // five bytes past the first packet, four of them fill the fifo while it is sent
        for (int i = 0; i <= 1028; i++)
            u_srpp_far_model.send_q.push_back(i[7:0]);
        wait_pkts(1);
        for (int i = 0; i < 1024; i++)
            bad += int'(u_srpp_far_model.got_q[i] !== i[7:0]);
        `CHK("full len", int'(BUF_BYTES), u_srpp_far_model.len_q[0])
        `CHK("full data", 0, bad)
        `CHK("fifo stall", 1'b1, u_srpp_far_model.refused > 0)
        repeat (200) @(posedge clk_sys);
        `CHK("no timeout", 1, u_srpp_far_model.len_q.size())
        slow <= 1'b0;
        apb(1'b1, OFS_TIMEOUT, 32'd12);
        wait_pkts(2);
        `CHK("tail len", 5, u_srpp_far_model.len_q[1])
        `CHK("tail byte", 8'h00, u_srpp_far_model.got_q[1024])
        apb(1'b0, OFS_FLUSHES, 32'h0);
        `CHK("flushes", 32'h2, rd)
        $display("test full done");
    endtask : test_full

    task test_len;
        clear();
        apb(1'b1, OFS_PKTLEN, 32'd3);
        for (int i = 0; i < 5; i++)
            u_srpp_far_model.send_q.push_back(8'h40 + i[7:0]);
        wait_pkts(2);
        `CHK("len pkt", 3, u_srpp_far_model.len_q[0])
        `CHK("idle pkt", 2, u_srpp_far_model.len_q[1])
        apb(1'b1, OFS_PKTLEN, 32'h0);
        $display("test len done");
    endtask : test_len

    task test_term;
        logic [7:0] t;
        apb(1'b1, OFS_DELIM, 32'h0a0d);
        for (int m = 0; m < 4; m++)
        begin
            clear();
            t = m[0] ? 8'h0a : 8'h0d;
            apb(1'b1, OFS_CTRL, {26'h0, m[1:0], 1'b0, m != 0, 2'b11});
            u_srpp_far_model.send_q = '{8'h11, t, 8'h22, 8'h33, 8'h44};
            wait_pkts(2);
            `CHK("first len", FIRST[m], u_srpp_far_model.len_q[0])
            `CHK("total", m == 3 ? 4 : 5, u_srpp_far_model.got_q.size())
            `CHK("byte 1", m == 3 ? 8'h22 : t, u_srpp_far_model.got_q[1])
            `CHK("byte 0", 8'h11, u_srpp_far_model.got_q[0])
        end
        $display("test term done");
    endtask : test_term

    task test_off;
        clear();
        apb(1'b1, OFS_CTRL, 32'h0);
        repeat (3) @(posedge clk_sys);
        u_srpp_far_model.send_q = '{8'h55, 8'h66};
        repeat (40) @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK("rx stalled", 1'b0, rx_ready)
        `CHK("none sent", 0, u_srpp_far_model.len_q.size())
        $display("test off done");
    endtask : test_off

    task results;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results

    // hang guard, well above the few thousand cycles needed
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 50000)
        begin
            num_errors++;
            results();
        end
    end

    // main sequence
    initial
    begin
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        test_regs();
        test_full();
        test_len();
        test_term();
        test_off();
        results();
    end
endmodule : test_serial_rx_packet_packer

`default_nettype wire
